// File: design/ipc_pkg.sv
// Purpose: Shared constants for the input pair configuration decoder
// Assumes: 16-bit configuration words, sent most significant bit first
// Notes:   Register fields sit at the same place in both setup words
package ipc_pkg;

	// ==================================================
	// Frame layout
	localparam int          FRAME_BITS   = 16;     // Bits in one word
	localparam int          WORD_MSB     = 15;     // Config / mode flag
	localparam int          SEL_HI       = 15;     // Select code, top
	localparam int          SEL_LO       = 11;     // Select code, bottom
	localparam int          SYNC_STAGES  = 3;      // Pin synchroniser depth

	// ==================================================
	// Select codes
	localparam logic [4:0]  DIFF_CFG_SELECT_CODE   = 5'h11; // Differential setup
	localparam logic [4:0]  CODING_CFG_SELECT_CODE = 5'h12; // Coding setup

	// ==================================================
	// Field positions
	localparam int          NUM_PAIRS    = 8;      // Input pairs
	localparam int          PAIR_HI      = 10;     // Pair 0 bit
	localparam int          PAIR_LO      = 3;      // Pair 7 bit
	localparam int          COMMON_BIT   = 2;      // Shared common reference
	localparam logic [3:0]  COMMON_INPUT = 4'hF;   // Input used as common

	// ==================================================
	// Reset values
	localparam logic [7:0]  PAIR_DIFF_RESET   = 8'h00; // All single-ended
	localparam logic        COMMON_RESET      = 1'h0;  // Common mode off
	localparam logic [7:0]  PAIR_CODING_RESET = 8'h00; // All unipolar

endpackage

// File: design/ipc_pin_sync.sv
// Purpose: Bring asynchronous pins into the clock domain
// Assumes: Pins change slowly against the clock
// Notes:   A change counts once the second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module ipc_pin_sync
	import ipc_pkg::*;
#(
	parameter int          WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// Pins in, filtered levels out
	input  wire logic [WIDTH-1:0]  pin,
	output logic      [WIDTH-1:0]  level
);

	// ==================================================
	// Stages
	logic [WIDTH-1:0] stage1;     // Read only by stage2
	logic [WIDTH-1:0] stage2;     // Second stage
	logic [WIDTH-1:0] stage3;     // Third stage
	logic [WIDTH-1:0] next_level; // Filtered next value

	// Accept a bit only where the last two stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
		end
	end

	// Shift chain and filtered level
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
			level  <= RESET_VALUE;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
		end
	end

endmodule
`default_nettype wire

// File: design/ipc_frame_rx.sv
// Purpose: Collect one 16-bit word from the 3-wire serial frame
// Assumes: Inputs are already synchronised and filtered
// Notes:   Bits past the sixteenth are ignored until select rises
`timescale 1ns/1ns
`default_nettype none
module ipc_frame_rx
	import ipc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// Filtered link levels
	input  wire logic                   cs_b,
	input  wire logic                   sclk,
	input  wire logic                   din,
	// Received word
	output logic                        word_valid,
	output logic [FRAME_BITS-1:0]       word
);

	// ==================================================
	// State
	logic                   sclk_prev;       // Last link clock level
	logic [4:0]             bit_count;       // Bits taken this frame
	logic                   frame_done;      // Word already delivered
	logic [FRAME_BITS-1:0]  shift;           // Assembly register
	logic                   next_sclk_prev;  // Next clock level
	logic [4:0]             next_bit_count;  // Next count
	logic                   next_frame_done; // Next done flag
	logic [FRAME_BITS-1:0]  next_shift;      // Next assembly
	logic                   next_word_valid; // Next strobe
	logic [FRAME_BITS-1:0]  next_word;       // Next word
	logic                   sclk_rise;       // Rising link clock

	assign sclk_rise = sclk && !sclk_prev;

	// Shift on each rising link clock while selected, up to the sixteenth bit
	always_comb begin
		next_sclk_prev  = sclk;
		next_bit_count  = bit_count;
		next_frame_done = frame_done;
		next_shift      = shift;
		next_word_valid = 1'b0;
		next_word       = word;
		if (cs_b) begin
			// Deselected: a short frame is dropped
			next_bit_count  = 5'h00;
			next_frame_done = 1'b0;
		end else if (sclk_rise && !frame_done) begin
			next_shift     = {shift[FRAME_BITS-2:0], din};
			next_bit_count = bit_count + 5'h01;
			if (bit_count == 5'(FRAME_BITS - 1)) begin
				// Sixteenth bit completes the word
				next_word_valid = 1'b1;
				next_word       = {shift[FRAME_BITS-2:0], din};
				next_frame_done = 1'b1;
			end
		end
	end

	// Register the frame state
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sclk_prev  <= 1'b0;
			bit_count  <= 5'h00;
			frame_done <= 1'b0;
			shift      <= 16'h0000;
			word_valid <= 1'b0;
			word       <= 16'h0000;
		end else begin
			sclk_prev  <= next_sclk_prev;
			bit_count  <= next_bit_count;
			frame_done <= next_frame_done;
			shift      <= next_shift;
			word_valid <= next_word_valid;
			word       <= next_word;
		end
	end

endmodule
`default_nettype wire

// File: design/ipc_input_pair_config_decoder.sv
// Purpose: Decode pair setup words and resolve per-channel input mode
// Assumes: Host drives the serial link; converter supplies busy/start
// Notes:   Settings for a conversion are frozen at its start strobe
`timescale 1ns/1ns
`default_nettype none
module ipc_input_pair_config_decoder
	import ipc_pkg::*;
(
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_b,
	// Serial link pins
	input  wire logic         cs_b,
	input  wire logic         sclk,
	input  wire logic         din,
	// Converter handshake
	input  wire logic         conv_busy,
	input  wire logic         conv_start,
	input  wire logic [3:0]   single_channel_selector,
	// Stored settings
	output logic [7:0]        pair_differential_config,
	output logic              shared_common_reference_bit,
	output logic [7:0]        pair_bipolar_coding,
	// Resolved channel setup
	output logic              pair_differential,
	output logic              common_referenced,
	output logic              twos_complement,
	output logic [3:0]        positive_input,
	output logic [3:0]        negative_input,
	// Mode control words and data validity
	output logic              mode_word_valid,
	output logic [14:0]       mode_word,
	output logic              data_invalid
);

	// ==================================================
	// Link front end
	logic [2:0]            link_level;  // Filtered cs_b, sclk, din
	logic                  word_valid;  // One word received
	logic [FRAME_BITS-1:0] word;        // Received word

	ipc_pin_sync #(
		.WIDTH       (3),
		.RESET_VALUE (3'h4)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.pin   ({cs_b, sclk, din}),
		.level (link_level)
	);

	ipc_frame_rx u_rx (
		.clock      (clock),
		.rst_b      (rst_b),
		.cs_b       (link_level[2]),
		.sclk       (link_level[1]),
		.din        (link_level[0]),
		.word_valid (word_valid),
		.word       (word)
	);

	// ==================================================
	// Helpers

	// Pick the setting bit of the pair holding a channel
	function automatic logic pair_bit(input logic [7:0] field,
		input logic [3:0] channel);
		logic [2:0] pair;
		pair = channel[3:1];
		pair_bit = field[3'(NUM_PAIRS - 1) - pair];
	endfunction

	// ==================================================
	// Word classification
	logic        is_setup;     // Top bit set
	logic        is_diff_cfg;  // Differential setup word
	logic        is_code_cfg;  // Coding setup word
	logic        is_mode;      // Mode control word
	logic [4:0]  select_code;  // Top five bits

	assign select_code = word[SEL_HI:SEL_LO];
	assign is_setup    = word_valid && word[WORD_MSB];
	assign is_mode     = word_valid && !word[WORD_MSB];
	assign is_diff_cfg = is_setup && (select_code == DIFF_CFG_SELECT_CODE);
	assign is_code_cfg = is_setup && (select_code == CODING_CFG_SELECT_CODE);

	// ==================================================
	// Setup registers
	logic [7:0] next_diff;    // Next differential field
	logic       next_common;  // Next common bit
	logic [7:0] next_coding;  // Next coding field

	// Load fields; low unused bits are dropped
	always_comb begin
		next_diff   = pair_differential_config;
		next_common = shared_common_reference_bit;
		next_coding = pair_bipolar_coding;
		if (is_diff_cfg) begin
			next_diff   = word[PAIR_HI:PAIR_LO];
			next_common = word[COMMON_BIT];
		end
		if (is_code_cfg) begin
			next_coding = word[PAIR_HI:PAIR_LO];
		end
	end

	// Register the fields
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pair_differential_config    <= PAIR_DIFF_RESET;
			shared_common_reference_bit <= COMMON_RESET;
			pair_bipolar_coding         <= PAIR_CODING_RESET;
		end else begin
			pair_differential_config    <= next_diff;
			shared_common_reference_bit <= next_common;
			pair_bipolar_coding         <= next_coding;
		end
	end

	// ==================================================
	// Channel resolution
	logic       sel_diff;       // Pair differential bit
	logic       sel_bip;        // Pair bipolar bit
	logic       next_pair;      // Next pair flag
	logic       next_comref;    // Next common flag
	logic       next_twos;      // Next coding flag
	logic [3:0] next_pos;       // Next positive input
	logic [3:0] next_neg;       // Next negative input

	assign sel_diff = pair_bit(pair_differential_config, single_channel_selector);
	assign sel_bip  = pair_bit(pair_bipolar_coding, single_channel_selector);

	// Priority: common, then differential, then bipolar
	always_comb begin
		next_pair   = pair_differential;
		next_comref = common_referenced;
		next_twos   = twos_complement;
		next_pos    = positive_input;
		next_neg    = negative_input;
		if (conv_start) begin
			next_pos = single_channel_selector;
			next_neg = 4'h0;
			if (shared_common_reference_bit) begin
				// Against shared input, unipolar binary
				next_pair   = 1'b0;
				next_comref = 1'b1;
				next_twos   = 1'b0;
				next_neg    = COMMON_INPUT;
			end else if (sel_diff) begin
				// Differential register takes precedence
				next_pair   = 1'b1;
				next_comref = 1'b0;
				next_twos   = 1'b0;
			end else if (sel_bip) begin
				// Bipolar pair, twos complement output
				next_pair   = 1'b1;
				next_comref = 1'b0;
				next_twos   = 1'b1;
			end else begin
				// Single-ended unipolar
				next_pair   = 1'b0;
				next_comref = 1'b0;
				next_twos   = 1'b0;
			end
			if (next_pair) begin
				// Either channel of a pair converts the pair
				next_pos = {single_channel_selector[3:1], 1'b0};
				next_neg = {single_channel_selector[3:1], 1'b1};
			end
		end
	end

	// Hold the setup for the running conversion
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pair_differential <= 1'b0;
			common_referenced <= 1'b0;
			twos_complement   <= 1'b0;
			positive_input    <= 4'h0;
			negative_input    <= 4'h0;
		end else begin
			pair_differential <= next_pair;
			common_referenced <= next_comref;
			twos_complement   <= next_twos;
			positive_input    <= next_pos;
			negative_input    <= next_neg;
		end
	end

	// ==================================================
	// Mode words and data validity
	logic        next_mode_valid;   // Next mode strobe
	logic [14:0] next_mode_word;    // Next mode payload
	logic        next_invalid;      // Next invalid flag

	// Setup mid-sequence spoils data; a mode word restores it
	always_comb begin
		next_mode_valid = is_mode;
		next_mode_word  = mode_word;
		next_invalid    = data_invalid;
		if (is_mode) begin
			next_mode_word = word[WORD_MSB-1:0];
			next_invalid   = 1'b0;
		end
		if (is_setup && conv_busy) begin
			next_invalid = 1'b1;
		end
	end

	// Register mode outputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_word_valid <= 1'b0;
			mode_word       <= 15'h0000;
			data_invalid    <= 1'b0;
		end else begin
			mode_word_valid <= next_mode_valid;
			mode_word       <= next_mode_word;
			data_invalid    <= next_invalid;
		end
	end

	// ==================================================
	// Checks

	chk_diff_write_load: assert property (
		@(posedge clock) disable iff (!rst_b)
		(word_valid && word[15:11] == 5'h11)
		|=> pair_differential_config == $past(word[10:3])
		&& shared_common_reference_bit == $past(word[2]))
		else $error("differential setup word not loaded");

	chk_coding_write_load: assert property (
		@(posedge clock) disable iff (!rst_b)
		(word_valid && word[15:11] == 5'h12)
		|=> pair_bipolar_coding == $past(word[10:3]))
		else $error("coding setup word not loaded");

	chk_other_code_ignored: assert property (
		@(posedge clock) disable iff (!rst_b)
		(word_valid && word[15:11] != 5'h11)
		|=> $stable(pair_differential_config))
		else $error("differential field changed by other word");

	chk_common_forces_unipolar: assert property (
		@(posedge clock) disable iff (!rst_b)
		(conv_start && shared_common_reference_bit)
		|=> common_referenced && !pair_differential && !twos_complement
		&& negative_input == 4'hF)
		else $error("common reference not applied");

	chk_diff_priority_win: assert property (
		@(posedge clock) disable iff (!rst_b)
		(conv_start && !shared_common_reference_bit && sel_diff)
		|=> pair_differential && !twos_complement
		&& positive_input == {$past(single_channel_selector[3:1]), 1'b0})
		else $error("differential pair not unipolar");

	chk_bipolar_pair_coding: assert property (
		@(posedge clock) disable iff (!rst_b)
		(conv_start && !shared_common_reference_bit && !sel_diff && sel_bip)
		|=> pair_differential && twos_complement
		&& negative_input == {$past(single_channel_selector[3:1]), 1'b1})
		else $error("bipolar pair not twos complement");

	chk_single_ended_default: assert property (
		@(posedge clock) disable iff (!rst_b)
		(conv_start && !shared_common_reference_bit && !sel_diff && !sel_bip)
		|=> !pair_differential && !twos_complement && !common_referenced
		&& positive_input == $past(single_channel_selector))
		else $error("single-ended setup wrong");

	chk_invalid_on_setup: assert property (
		@(posedge clock) disable iff (!rst_b)
		(word_valid && word[15] && conv_busy) |=> data_invalid)
		else $error("setup during conversion left data valid");

	chk_mode_clears_invalid: assert property (
		@(posedge clock) disable iff (!rst_b)
		(word_valid && !word[15]) |=> !data_invalid && mode_word_valid)
		else $error("mode word did not restore data");

	chk_hold_between_starts: assert property (
		@(posedge clock) disable iff (!rst_b)
		!conv_start |=> $stable(twos_complement) && $stable(pair_differential))
		else $error("resolved setup changed without start");

endmodule
`default_nettype wire

// File: tb/ipc_host_model.sv
// Purpose: Host side of the 3-wire serial link, sends setup and mode words
// Assumes: Link clock idles low, four system clocks per half period (400 ns)
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module ipc_host_model (
	// System clock
	input  wire logic clock,
	// Serial link pins
	output var  logic cs_b,
	output var  logic sclk,
	output var  logic din
);
	// ==================================================
	// Idle levels from time zero, link clock stands low
	initial begin
		cs_b = 1'h1;
		sclk = 1'h0;
		din  = 1'h0;
	end

	// ==================================================
	// One frame of nbits, most significant bit first
	task automatic send(input logic [15:0] w, input int nbits);
		@(posedge clock);
		cs_b <= 1'h0;
		// Data set up half a link period before the rising edge
		for (int i = 15; i > 15 - nbits; i--) begin
			din <= w[i];
			repeat (4) @(posedge clock);
			sclk <= 1'h1;
			repeat (4) @(posedge clock);
			sclk <= 1'h0;
		end
		repeat (4) @(posedge clock);
		// Release: no pull, so show a changed level
		cs_b <= 1'h1;
		din  <= ~din;
		// Stay deselected long enough for the pin filter to see it
		repeat (4) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// File: tb/ipc_input_pair_config_decoder_tb.sv
// Purpose: Self-checking bench for the input pair configuration decoder
// Assumes: Host model drives the link, bench drives the converter side
// Notes:   Expected setups are worked out here from the pair bits
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module ipc_input_pair_config_decoder_tb import ipc_pkg::*;;
	// ==================================================
	// Signals
	logic        clock = 1'h0;      // System clock
	logic        rst_b = 1'h0;      // Reset, active low
	wire logic   cs_b;              // Link select
	wire logic   sclk;              // Link clock
	wire logic   din;               // Link data
	logic        conv_busy = 1'h0;  // Sequence running
	logic        conv_start = 1'h0; // Freeze strobe
	logic [3:0]  single_channel_selector = 4'h0;
	logic [7:0]  pair_differential_config;
	logic        shared_common_reference_bit;
	logic [7:0]  pair_bipolar_coding;
	logic        pair_differential;
	logic        common_referenced;
	logic        twos_complement;
	logic [3:0]  positive_input;
	logic [3:0]  negative_input;
	logic        mode_word_valid;
	logic [14:0] mode_word;
	logic        data_invalid;
	wire  [10:0] resolved;          // Packed resolved setup
	int          fails = 0;         // Mismatches
	int          num_checks = 0;    // Comparisons
	int          mode_pulses = 0;   // Mode word strobes seen
	int          cycles = 0;        // Timeout counter

	assign resolved = {pair_differential, common_referenced, twos_complement,
		positive_input, negative_input};

	// ==================================================
	// Clock, 100 ns period
	always #50 clock = ~clock;

	ipc_host_model host (
		.clock (clock),
		.cs_b  (cs_b),
		.sclk  (sclk),
		.din   (din)
	);

	ipc_input_pair_config_decoder uut (
		.clock                       (clock),
		.rst_b                       (rst_b),
		.cs_b                        (cs_b),
		.sclk                        (sclk),
		.din                         (din),
		.conv_busy                   (conv_busy),
		.conv_start                  (conv_start),
		.single_channel_selector     (single_channel_selector),
		.pair_differential_config    (pair_differential_config),
		.shared_common_reference_bit (shared_common_reference_bit),
		.pair_bipolar_coding         (pair_bipolar_coding),
		.pair_differential           (pair_differential),
		.common_referenced           (common_referenced),
		.twos_complement             (twos_complement),
		.positive_input              (positive_input),
		.negative_input              (negative_input),
		.mode_word_valid             (mode_word_valid),
		.mode_word                   (mode_word),
		.data_invalid                (data_invalid)
	);

	// ==================================================
	// Count mode strobes and cut a hang short
	always @(posedge clock) begin
		cycles++;
		if (mode_word_valid === 1'h1) begin
			mode_pulses++;
		end
		if (cycles == 5000) begin
			fails++;
			conclude();
		end
	end

	// Expected {pair, common, twos, positive, negative} for one channel
	function automatic logic [10:0] expect_setup(input logic [7:0] d, input logic com,
		input logic [7:0] b, input logic [3:0] ch);
		logic [2:0] p;
		p = ch[3:1];
		// Common bit wins over both pair bits
		if (com) return {3'h2, ch, COMMON_INPUT};
		// Differential bit wins over coding bit
		if (d[~p]) return {3'h4, p, 1'h0, p, 1'h1};
		if (b[~p]) return {3'h5, p, 1'h0, p, 1'h1};
		return {3'h0, ch, 4'h0};
	endfunction

	// Strobe one channel and compare the frozen setup
	task automatic resolve(input logic [3:0] ch, input logic [10:0] e);
		@(posedge clock);
		conv_start              <= 1'h1;
		single_channel_selector <= ch;
		@(posedge clock);
		conv_start <= 1'h0;
		@(posedge clock);
		@(negedge clock);
		`CHK(resolved, e)
	endtask

	// Let a received word reach the registers
	task automatic settle();
		repeat (8) @(posedge clock);
		@(negedge clock);
	endtask

	// Counts, then verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'h1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		// Reset state
		`CHK({pair_differential_config, shared_common_reference_bit}, 9'h000)
		`CHK({pair_bipolar_coding, data_invalid}, 9'h000)
		resolve(4'h5, {3'h0, 4'h5, 4'h0});
		// Differential word, unused low bits set
		host.send({DIFF_CFG_SELECT_CODE, 8'hA5, 3'h3}, 16);
		settle();
		`CHK({pair_differential_config, shared_common_reference_bit}, 9'h14A)
		`CHK(data_invalid, 1'h0)
		host.send({CODING_CFG_SELECT_CODE, 8'h3C, 3'h7}, 16);
		settle();
		`CHK(pair_bipolar_coding, 8'h3C)
		// Another code and a short frame leave both registers alone
		host.send({5'h13, 8'hFF, 3'h7}, 16);
		host.send({DIFF_CFG_SELECT_CODE, 8'hFF, 3'h7}, 10);
		settle();
		`CHK({pair_differential_config, pair_bipolar_coding}, 16'hA53C)
		// Every channel, all four pair combinations present
		for (int c = 0; c < 16; c++)
			resolve(c[3:0], expect_setup(8'hA5, 1'h0, 8'h3C, c[3:0]));
		// Common reference on
		host.send({DIFF_CFG_SELECT_CODE, 8'hA5, 3'h4}, 16);
		settle();
		`CHK(shared_common_reference_bit, 1'h1)
		for (int c = 0; c < 15; c++)
			resolve(c[3:0], expect_setup(8'hA5, 1'h1, 8'h3C, c[3:0]));
		// Setup word during a sequence: frozen setup, data marked bad
		@(posedge clock);
		conv_busy <= 1'h1;
		host.send({DIFF_CFG_SELECT_CODE, 8'h00, 3'h0}, 16);
		settle();
		`CHK(data_invalid, 1'h1)
		`CHK({pair_differential_config, shared_common_reference_bit}, 9'h000)
		`CHK(resolved, {3'h2, 4'hE, 4'hF})
		@(posedge clock);
		conv_busy <= 1'h0;
		// Mode word clears the bad-data mark
		host.send(16'h1234, 16);
		settle();
		`CHK(mode_pulses, 1)
		`CHK({mode_word, data_invalid}, 16'h2468)
		resolve(4'h4, {3'h5, 4'h4, 4'h5});
		conclude();
	end
endmodule
`undef CHK
`default_nettype wire
